/* File: core/clk_exit_consts.svh */
// Constants for the processor clock-control exit sequencer
// Operation
// RULE1: Resolution bit picks 1 ms or 8 us tick
// RULE2: Exit waits lock time plus 32 kHz period
// RULE3: Then 2-3 or 3-5 periods, negate stop
// RULE4: Suspend status negates first; 32 kHz counted
// RULE5: Expired device 3 idle timer raises burst; the code raises a break instead when the mode bit is clear
// RULE6: Burst event never loses the entry read
// RULE7: Software enables only idle timer before entry
// RULE8: External IDE accesses cause no reloads
// RULE9: Wake events break or burst by mode bit
// RULE10: Stop break ends control until new entry
`ifndef CLK_EXIT_CONSTS_SVH
`define CLK_EXIT_CONSTS_SVH
`define ADDR_W 8
`define OFS_LEVEL2_ENTRY_REGISTER 8'h14
`define OFS_LEVEL3_ENTRY_REGISTER 8'h18
`define OFS_CTRL 8'h40
`define OFS_IDLE3 8'h44
`define OFS_BURST_COUNT_CONTROL_B 8'h48
`define OFS_STATUS 8'h4C
`define OFS_MASK 8'h50
`define OFS_STATE 8'h54
`define RST_WORD 32'h0000_0000
`define BURST_COUNT_CONTROL_B_RES_BIT 5
`define CTRL_CC_EN 0
`define CTRL_SLEEP_EN 1
`define CTRL_MODE_SEL 2
`define CTRL_EV_EN 3
`define CTRL_IDLE3_EN 4
`define CTRL_IDLE3_RLD 5
`define CTRL_LOCK_LSB 8
`define CTRL_LOCK_MSB 15
`define CTRL_BLEN_LSB 16
`define CTRL_BLEN_MSB 23
`define ST_BURST 0
`define ST_BREAK 1
`define ST_EXIT 2
`define ST_IDLE3 3
`define EV_W 4
`define CORE_FREQ_KHZ 100000
`define SLOW_FREQ_KHZ 32
`define SLOW_CYCLES (`CORE_FREQ_KHZ / `SLOW_FREQ_KHZ)
`define COARSE_US 1000
`define FINE_US 8
`define US_TO_CYCLES(us) ((us) * `CORE_FREQ_KHZ / 1000)
`define TICK_W 17
`define SUS_SLOW_TICKS 8'h02
`define STOP_TICKS_AWAKE 8'h03
`define STOP_TICKS_SLEEP 8'h04
`define ONE_TICK 8'h01
`endif

/* File: core/clk_exit_pkg.sv */
// Types for the processor clock-control exit sequencer
package clk_exit_pkg;
  typedef enum logic [4:0] {
    ST_RUN   = 5'b0_0001,
    ST_CTRL  = 5'b0_0010,
    ST_LOCK  = 5'b0_0100,
    ST_STOP  = 5'b0_1000,
    ST_BURST = 5'b1_0000
  } seq_state_t;
endpackage

/* File: core/cpu_clock_control_exit_sequencer.sv */
// Processor clock-control entry, burst and stop-clock exit sequencer
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "clk_exit_consts.svh"
module cpu_clock_control_exit_sequencer #(
  parameter logic [16:0] COARSE_TICK_CYCLES = 17'(`US_TO_CYCLES(`COARSE_US))
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic wake_event,
  input wire logic device3_activity,
  input wire logic ide_external_access,
  output logic processor_clock_stop_request_n,
  output logic suspend_status_one_n,
  output logic irq,
  output clk_exit_pkg::seq_state_t seq_state
);
  import clk_exit_pkg::*;

  localparam logic [16:0] FINE_TICK_CYCLES = 17'(`US_TO_CYCLES(`FINE_US));
  localparam logic [16:0] SLOW_TICK_CYCLES = 17'(`SLOW_CYCLES);

  logic [31:0] ctrl_reg;
  logic [31:0] burst_count_control_b;
  logic [15:0] idle3_reload_reg;
  logic [15:0] idle3_cnt_reg;
  logic [`EV_W-1:0] status_reg;
  logic [`EV_W-1:0] mask_reg;
  logic [`EV_W-1:0] ev_set;
  logic [7:0] cnt_reg;
  logic lock_phase_reg;
  logic deep_reg;
  logic burst_flag_reg;
  logic pend_reg;
  logic fast_tick;
  logic slow_tick;
  logic lock_start;
  logic [16:0] fast_period;
  logic lvl_read;
  logic idle3_expire;
  logic ev_any;
  logic ev_burst;
  logic ev_break;
  seq_state_t state_next;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic reached(input logic [7:0] c, input logic [7:0] lim, input logic t);
    reached = t && (c + `ONE_TICK >= lim);
  endfunction

  wire cc_en = ctrl_reg[`CTRL_CC_EN];
  wire sleep_en = ctrl_reg[`CTRL_SLEEP_EN];
  wire mode_burst = ctrl_reg[`CTRL_MODE_SEL];
  wire ev_en = ctrl_reg[`CTRL_EV_EN];
  wire idle3_en = ctrl_reg[`CTRL_IDLE3_EN];
  wire idle3_rld = ctrl_reg[`CTRL_IDLE3_RLD];
  wire [7:0] lock_time = ctrl_reg[`CTRL_LOCK_MSB:`CTRL_LOCK_LSB];
  wire [7:0] burst_len = ctrl_reg[`CTRL_BLEN_MSB:`CTRL_BLEN_LSB];
  wire [7:0] stop_ticks = sleep_en ? `STOP_TICKS_SLEEP : `STOP_TICKS_AWAKE;

  // Fast lock-time timer granularity
  assign fast_period = burst_count_control_b[`BURST_COUNT_CONTROL_B_RES_BIT] ? FINE_TICK_CYCLES
                                                          : COARSE_TICK_CYCLES; // RULE1
  assign lock_start = (state_next == ST_LOCK) && (seq_state != ST_LOCK);

  tick_gen fast_timer (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .restart(lock_start),
    .period(fast_period),
    .tick(fast_tick)
  );

  tick_gen slow_timer (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .restart(1'b0),
    .period(SLOW_TICK_CYCLES),
    .tick(slow_tick)
  );

  assign lvl_read = rd && (hit(addr, `OFS_LEVEL2_ENTRY_REGISTER) || hit(addr, `OFS_LEVEL3_ENTRY_REGISTER));
  assign idle3_expire = idle3_en && slow_tick && (idle3_cnt_reg == 16'h0001); // RULE5
  assign ev_any = ev_en && (wake_event || idle3_expire);
  assign ev_burst = ev_any && mode_burst; // RULE9
  assign ev_break = ev_any && !mode_burst; // RULE9

  // Register writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_reg <= `RST_WORD;
      burst_count_control_b <= `RST_WORD;
      idle3_reload_reg <= 16'h0000;
      mask_reg <= 4'h0;
    end else if (ce && wr) begin
      if (hit(addr, `OFS_CTRL)) begin
        ctrl_reg <= wdata;
      end
      if (hit(addr, `OFS_BURST_COUNT_CONTROL_B)) begin
        burst_count_control_b <= wdata;
      end
      if (hit(addr, `OFS_IDLE3)) begin
        idle3_reload_reg <= wdata[15:0];
      end
      if (hit(addr, `OFS_MASK)) begin
        mask_reg <= wdata[`EV_W-1:0];
      end
    end
  end

  // Device 3 idle timer; external IDE accesses never reload it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      idle3_cnt_reg <= 16'h0000;
    end else if (ce) begin
      if (!idle3_en) begin
        idle3_cnt_reg <= idle3_reload_reg;
      end else if (idle3_rld && device3_activity && !ide_external_access) begin // RULE8
        idle3_cnt_reg <= idle3_reload_reg;
      end else if (slow_tick && idle3_cnt_reg != 16'h0000) begin
        idle3_cnt_reg <= idle3_cnt_reg - 16'h0001; // RULE5
      end
    end
  end

  // Sticky status, set wins over write-one-to-clear
  always_comb begin
    ev_set = 4'h0;
    ev_set[`ST_BURST] = ev_burst && (seq_state == ST_CTRL);
    ev_set[`ST_BREAK] = ev_break && (seq_state == ST_CTRL);
    ev_set[`ST_EXIT] = (seq_state == ST_STOP) && (state_next != ST_STOP);
    ev_set[`ST_IDLE3] = idle3_expire;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_reg <= 4'h0;
    end else if (ce) begin
      if (wr && hit(addr, `OFS_STATUS)) begin
        status_reg <= (status_reg & ~wdata[`EV_W-1:0]) | ev_set;
      end else begin
        status_reg <= status_reg | ev_set;
      end
    end
  end

  assign irq = |(status_reg & mask_reg);

  // Read port, data in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata <= `RST_WORD;
    end else if (ce) begin
      rdata <= `RST_WORD;
      if (rd) begin
        unique case (addr)
          `OFS_CTRL: rdata <= ctrl_reg;
          `OFS_BURST_COUNT_CONTROL_B: rdata <= burst_count_control_b;
          `OFS_IDLE3: rdata <= {idle3_cnt_reg, idle3_reload_reg};
          `OFS_STATUS: rdata <= {28'h000_0000, status_reg};
          `OFS_MASK: rdata <= {28'h000_0000, mask_reg};
          `OFS_STATE: rdata <= {24'h00_0000, pend_reg, processor_clock_stop_request_n,
                                suspend_status_one_n, seq_state};
          default: rdata <= `RST_WORD;
        endcase
      end
    end
  end

  // Sequencer next state
  always_comb begin
    state_next = seq_state;
    unique case (seq_state)
      ST_RUN: begin
        if (lvl_read && cc_en) begin
          state_next = ST_CTRL; // RULE6
        end
      end
      ST_CTRL: begin
        if (ev_any || pend_reg || !cc_en) begin
          state_next = deep_reg ? ST_LOCK : ST_STOP;
        end
      end
      ST_LOCK: begin
        if (lock_phase_reg && reached(cnt_reg, `SUS_SLOW_TICKS, slow_tick)) begin
          state_next = ST_STOP;
        end
      end
      ST_STOP: begin
        if (reached(cnt_reg, stop_ticks, slow_tick)) begin
          state_next = burst_flag_reg && cc_en ? ST_BURST : ST_RUN; // RULE10
        end
      end
      ST_BURST: begin
        if (!cc_en) begin
          state_next = ST_RUN;
        end else if (reached(cnt_reg, burst_len, slow_tick)) begin
          state_next = ST_CTRL;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      seq_state <= ST_RUN;
    end else if (ce) begin
      seq_state <= state_next;
    end
  end

  // Entry depth, burst flag and pending burst
  always_ff @(posedge core_clk) begin
    if (rst) begin
      deep_reg <= 1'b0;
      burst_flag_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else if (ce) begin
      if (seq_state == ST_RUN && lvl_read && cc_en) begin
        deep_reg <= hit(addr, `OFS_LEVEL3_ENTRY_REGISTER);
      end
      if (seq_state == ST_CTRL && state_next != ST_CTRL) begin
        burst_flag_reg <= (ev_burst || pend_reg) && cc_en; // RULE10
      end
      if (seq_state == ST_RUN && ev_burst) begin
        pend_reg <= 1'b1; // RULE6
      end else if (seq_state == ST_CTRL) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // Period counter for lock, stop and burst phases
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      lock_phase_reg <= 1'b0;
    end else if (ce) begin
      if (state_next != seq_state) begin
        cnt_reg <= 8'h00;
        lock_phase_reg <= 1'b0;
      end else if (seq_state == ST_LOCK && !lock_phase_reg) begin
        if (cnt_reg >= lock_time) begin
          cnt_reg <= 8'h00;
          lock_phase_reg <= 1'b1; // RULE2
        end else if (fast_tick) begin
          cnt_reg <= cnt_reg + `ONE_TICK; // RULE2
        end
      end else if (slow_tick) begin
        cnt_reg <= cnt_reg + `ONE_TICK; // RULE4
      end
    end
  end

  // Processor-facing outputs, active low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      processor_clock_stop_request_n <= 1'b1;
      suspend_status_one_n <= 1'b1;
    end else if (ce) begin
      if (state_next == ST_CTRL && seq_state != ST_CTRL) begin
        processor_clock_stop_request_n <= 1'b0;
        suspend_status_one_n <= !(seq_state == ST_RUN ? hit(addr, `OFS_LEVEL3_ENTRY_REGISTER) : deep_reg);
      end
      if (seq_state == ST_LOCK && state_next == ST_STOP) begin
        suspend_status_one_n <= 1'b1; // RULE2
      end
      if (seq_state == ST_STOP && state_next != ST_STOP) begin
        processor_clock_stop_request_n <= 1'b1; // RULE3
      end
    end
  end

  a_res_select: assert property (@(posedge core_clk) disable iff (rst) // RULE1
    fast_period == (burst_count_control_b[`BURST_COUNT_CONTROL_B_RES_BIT] ? FINE_TICK_CYCLES : COARSE_TICK_CYCLES))
    else $error("fast tick period wrong");
  a_sus_after_lock: assert property (@(posedge core_clk) disable iff (rst) // RULE2
    $rose(suspend_status_one_n) |-> $past(lock_phase_reg) && $past(slow_tick) && $past(seq_state) == ST_LOCK)
    else $error("suspend status negated before lock wait");
  a_stop_hold_gap: assert property (@(posedge core_clk) disable iff (rst) // RULE3
    $rose(suspend_status_one_n) |-> !processor_clock_stop_request_n [*8])
    else $error("stop request negated too soon");
  a_stop_on_tick: assert property (@(posedge core_clk) disable iff (rst) // RULE3
    $rose(processor_clock_stop_request_n) |-> $past(seq_state) == ST_STOP && $past(slow_tick))
    else $error("stop request negated off the slow tick");
  a_sus_first: assert property (@(posedge core_clk) disable iff (rst) // RULE4
    $rose(processor_clock_stop_request_n) |-> suspend_status_one_n)
    else $error("stop negated before suspend status");
  a_idle3_event: assert property (@(posedge core_clk) disable iff (rst) // RULE5
    ce && idle3_expire |=> status_reg[`ST_IDLE3])
    else $error("idle timer expiry not recorded");
  a_entry_kept: assert property (@(posedge core_clk) disable iff (rst) // RULE6
    ce && seq_state == ST_RUN && lvl_read && cc_en |=> seq_state == ST_CTRL && !processor_clock_stop_request_n)
    else $error("entry read lost");
  a_ext_no_reload: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    ce && idle3_en && ide_external_access && !slow_tick && !wr |=> $stable(idle3_cnt_reg))
    else $error("external IDE access reloaded idle timer");
  a_break_ends: assert property (@(posedge core_clk) disable iff (rst) // RULE10
    ce && seq_state == ST_CTRL && ev_break && !pend_reg |=> !burst_flag_reg)
    else $error("stop break did not end clock control");
  a_irq_level: assert property (@(posedge core_clk) disable iff (rst)
    irq == |(status_reg & mask_reg))
    else $error("interrupt level wrong");

  c_entry: cover property (@(posedge core_clk) disable iff (rst) seq_state == ST_RUN ##1 seq_state == ST_CTRL);
  c_burst_back: cover property (@(posedge core_clk) disable iff (rst) seq_state == ST_BURST ##1 seq_state == ST_CTRL);
  c_deep_exit: cover property (@(posedge core_clk) disable iff (rst) $rose(suspend_status_one_n));
  c_break_exit: cover property (@(posedge core_clk) disable iff (rst) seq_state == ST_STOP ##1 seq_state == ST_RUN);
endmodule
`default_nettype wire

/* File: core/tick_gen.sv */
// Periodic one-cycle tick generator with restart
`timescale 1ns/100ps
`default_nettype none
module tick_gen (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic restart,
  input wire logic [16:0] period,
  output logic tick
);
  logic [16:0] cnt_reg;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg <= 17'h0_0000;
      tick <= 1'b0;
    end else if (ce) begin
      if (restart || cnt_reg >= period - 17'h0_0001) begin
        cnt_reg <= 17'h0_0000;
      end else begin
        cnt_reg <= cnt_reg + 17'h0_0001;
      end
      tick <= !restart && (cnt_reg >= period - 17'h0_0001);
    end
  end
endmodule
`default_nettype wire

/* File: tb/cpu_clock_control_exit_sequencer_tb.sv */
// Self-checking testbench for the processor clock-control exit sequencer
`timescale 1ns/100ps
`default_nettype none
`include "clk_exit_consts.svh"
module cpu_clock_control_exit_sequencer_tb;
  import clk_exit_pkg::*;
  localparam int FAST_C = 50;
  localparam int SLOW = `SLOW_CYCLES;
  typedef struct {logic [31:0] exp; logic [31:0] msk;} note_t;
  logic core_clk, rst, ce, wr, rd, rd_d, wake_event, device3_activity, ide_external_access;
  logic stop_n, sus_n, irq, order_bad;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0] ofs[5] = '{`OFS_CTRL, `OFS_BURST_COUNT_CONTROL_B, `OFS_STATUS, `OFS_MASK, 8'hF0};
  seq_state_t seq_state;
  int miscompares = 0;
  int compares = 0;
  int tcyc = 0;
  int cyc, sus_at, stop_at;
  integer seed = 32'h5fe2;
  note_t notes[$];

  cpu_clock_control_exit_sequencer #(.COARSE_TICK_CYCLES(17'd50)) i_dut (
    .core_clk(core_clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .wake_event(wake_event), .device3_activity(device3_activity),
    .ide_external_access(ide_external_access), .processor_clock_stop_request_n(stop_n),
    .suspend_status_one_n(sus_n), .irq(irq), .seq_state(seq_state)
  );
  proc_model i_proc (
    .core_clk(core_clk), .stop_n(stop_n), .sus_n(sus_n), .cyc(cyc), .sus_at(sus_at),
    .stop_at(stop_at), .order_bad(order_bad)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi);
    compares++;
    if (v < lo || v > hi) begin
      miscompares++;
      $display("unexpected at %0t: %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    notes.push_back('{e, m});
    @(posedge core_clk);
    rd <= 1'b0;
  endtask

  task automatic wait_st(input seq_state_t s, input int lim);
    int n;
    n = 0;
    #1;
    while (seq_state !== s && n < lim) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk({27'h0, seq_state}, {27'h0, s});
  endtask

  task automatic irq_is(input logic v);
    #1;
    chk({31'h0, irq}, {31'h0, v});
  endtask

  task automatic exit_seq(input logic res, input int lock, input logic sleep, input logic level3_entry_register);
    logic [31:0] w;
    int t0, tk, sa, d0, d1;
    tk = res ? `US_TO_CYCLES(`FINE_US) : FAST_C;
    d0 = sleep ? 3 * SLOW : 2 * SLOW;
    d1 = sleep ? 5 * SLOW : 3 * SLOW;
    w = $random(seed);
    w[`BURST_COUNT_CONTROL_B_RES_BIT] = res;
    wr_reg(`OFS_BURST_COUNT_CONTROL_B, w);
    rd_reg(`OFS_BURST_COUNT_CONTROL_B, w, 32'hFFFF_FFFF);
    wr_reg(`OFS_CTRL, 32'h0000_0009 | {30'h0, sleep, 1'b0} | (32'(lock) << 8));
    rd_reg(level3_entry_register ? `OFS_LEVEL3_ENTRY_REGISTER : `OFS_LEVEL2_ENTRY_REGISTER, 32'h0, 32'hFFFF_FFFF);
    repeat (3) @(posedge core_clk);
    #1;
    chk({29'h0, seq_state === ST_CTRL, stop_n, sus_n}, {29'h0, 2'b10, ~level3_entry_register});
    sa = sus_at;
    @(posedge core_clk);
    wake_event <= 1'b1;
    t0 = cyc;
    @(posedge core_clk);
    wake_event <= 1'b0;
    wait_st(ST_RUN, 8 * SLOW + lock * tk);
    @(posedge core_clk);
    #1;
    if (level3_entry_register) begin
      rng(sus_at - t0, lock * tk + SLOW, lock * tk + 2 * SLOW + 6);
    end else begin
      rng(sus_at, sa, sa);
    end
    rng(stop_at - (level3_entry_register ? sus_at : t0), d0, d1 + 6);
    chk({31'h0, order_bad}, 32'h0);
    rd_reg(`OFS_STATUS, 32'h6, 32'h6);
    wr_reg(`OFS_STATUS, 32'hF);
    rd_reg(`OFS_STATUS, 32'h0, 32'hF);
  endtask

  always @(posedge core_clk) begin
    if (rd_d) begin
      chk(rdata & notes[0].msk, notes[0].exp);
      void'(notes.pop_front());
    end
    rd_d <= rd;
  end

  always @(posedge core_clk) begin
    tcyc <= tcyc + 1;
    if (tcyc == 100000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    rd_d = 1'b0;
    wake_event = 1'b0;
    device3_activity = 1'b0;
    ide_external_access = 1'b0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    irq_is(1'b0);
    wr_reg(8'hF0, $random(seed));
    foreach (ofs[i]) begin
      rd_reg(ofs[i], 32'h0, 32'hFFFF_FFFF);
    end
    rd_reg(`OFS_STATE, 32'h61, 32'hFF);
    exit_seq(1'b1, 3, 1'b0, 1'b1);
    exit_seq(1'b0, 4, 1'b1, 1'b1);
    exit_seq(1'b0, 2, 1'b0, 1'b0);
    wr_reg(`OFS_MASK, 32'h1);
    wr_reg(`OFS_IDLE3, 32'h0000_0002);
    wr_reg(`OFS_CTRL, 32'h0001_001D);
    rd_reg(`OFS_LEVEL2_ENTRY_REGISTER, 32'h0, 32'hFFFF_FFFF);
    wait_st(ST_BURST, 5 * SLOW + 10);
    irq_is(1'b1);
    wr_reg(`OFS_MASK, 32'h0);
    irq_is(1'b0);
    wr_reg(`OFS_MASK, 32'h1);
    irq_is(1'b1);
    wr_reg(`OFS_STATUS, 32'h1);
    irq_is(1'b0);
    wr_reg(`OFS_CTRL, 32'h0001_0035);
    wait_st(ST_CTRL, 2 * SLOW + 10);
    wr_reg(`OFS_STATUS, 32'hF);
    device3_activity <= 1'b1;
    repeat (2 * SLOW + 10) @(posedge core_clk);
    rd_reg(`OFS_STATUS, 32'h0, 32'h8);
    ide_external_access <= 1'b1;
    wait_st(ST_CTRL, 0);
    repeat (2 * SLOW + 10) @(posedge core_clk);
    rd_reg(`OFS_STATUS, 32'h8, 32'h8);
    device3_activity <= 1'b0;
    ide_external_access <= 1'b0;
    wait_st(ST_CTRL, 0);
    wr_reg(`OFS_CTRL, 32'h0001_0009);
    @(posedge core_clk);
    wake_event <= 1'b1;
    @(posedge core_clk);
    wake_event <= 1'b0;
    wait_st(ST_RUN, 4 * SLOW + 10);
    wr_reg(`OFS_CTRL, 32'h0001_000D);
    @(posedge core_clk);
    wake_event <= 1'b1;
    @(posedge core_clk);
    wake_event <= 1'b0;
    rd_reg(`OFS_STATE, 32'hE1, 32'hFF);
    rd_reg(`OFS_LEVEL2_ENTRY_REGISTER, 32'h0, 32'hFFFF_FFFF);
    wait_st(ST_BURST, 3 * SLOW + 10);
    wr_reg(`OFS_CTRL, 32'h0);
    wait_st(ST_RUN, 10);
    rd_reg(`OFS_STATE, 32'h61, 32'hFF);
    repeat (3) @(posedge core_clk);
    results();
  end
endmodule
`default_nettype wire

/* File: tb/proc_model.sv */
// Host processor model watching the stop-clock and suspend status lines
`timescale 1ns/100ps
`default_nettype none
module proc_model (
  input wire logic core_clk,
  input wire logic stop_n,
  input wire logic sus_n,
  output int cyc,
  output int sus_at,
  output int stop_at,
  output logic order_bad
);
  logic stop_d;
  logic sus_d;
  initial begin
    cyc = 0;
    sus_at = 0;
    stop_at = 0;
    order_bad = 1'b0;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    stop_d <= stop_n;
    sus_d <= sus_n;
    if (sus_n === 1'b1 && sus_d === 1'b0) begin
      sus_at <= cyc;
    end
    if (stop_n === 1'b1 && stop_d === 1'b0) begin
      stop_at <= cyc;
      if (sus_n !== 1'b1) begin
        order_bad <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire
